// file: mfsr_pkg.sv
/*
  Constants shared by the frame statistics and receive stream block:
  bit positions of the transmit statistics word, frame byte codes,
  register offsets and bus response codes.
  Assumes nothing of its surroundings; import with mfsr_pkg::*.
*/
`default_nettype none
package mfsr_pkg;
  // ------------------------------------------------------------
  // Transmit statistics word layout
  // ------------------------------------------------------------
  localparam int TXS_W       = 32;  // Base width of the word
  localparam int TXS_PFC     = 32;  // Own priority flow frame sent
  localparam int TXS_PAUSE   = 31;  // Own pause frame sent
  localparam int TXS_BYTE    = 30;  // Frame byte in flight
  localparam int TXS_RSV_HI  = 29;  // Reserved, zero
  localparam int TXS_ATT_HI  = 28;  // Attempts minus one
  localparam int TXS_ATT_LO  = 25;
  localparam int TXS_RSV_LO  = 24;  // Reserved, zero
  localparam int TXS_XCOL    = 23;  // Collision on all 16 attempts
  localparam int TXS_LATE    = 22;  // Late collision
  localparam int TXS_XDEF    = 21;  // Deferral limit hit
  localparam int TXS_DEF     = 20;  // Deferred at all
  localparam int TXS_VLAN    = 19;  // Tagged frame
  localparam int TXS_LEN_HI  = 18;  // Byte length
  localparam int TXS_LEN_LO  = 5;
  localparam int TXS_CTRL    = 4;   // MAC control type
  localparam int TXS_UNDR    = 3;   // Underrun
  localparam int TXS_MCAST   = 2;   // Multicast destination
  localparam int TXS_BCAST   = 1;   // Broadcast destination
  localparam int TXS_CLEAN   = 0;   // Sent without error
  // ------------------------------------------------------------
  // Frame decode
  // ------------------------------------------------------------
  localparam logic [13:0] LEN_SAT    = 14'h3FF0;  // 16368 bytes
  localparam logic [4:0]  ATT_MAX    = 5'h10;     // 16 attempts
  localparam logic [3:0]  IDX_DA0    = 4'h0;      // First DA byte
  localparam logic [3:0]  IDX_DA5    = 4'h5;      // Last DA byte
  localparam logic [3:0]  IDX_TYPE_H = 4'hC;      // Type high byte
  localparam logic [3:0]  IDX_TYPE_L = 4'hD;      // Type low byte
  localparam logic [3:0]  IDX_END    = 4'hE;      // Decode finished
  localparam logic [7:0]  BYTE_ALL1  = 8'hFF;
  localparam logic [7:0]  CTL_TYPE_H = 8'h88;
  localparam logic [7:0]  CTL_TYPE_L = 8'h08;
  localparam logic [7:0]  TAG_TYPE_H = 8'h81;
  localparam logic [7:0]  TAG_TYPE_L = 8'h00;
  // ------------------------------------------------------------
  // Register map and bus answers
  // ------------------------------------------------------------
  localparam logic [3:0]  REG_CTRL   = 4'h0;  // Control
  localparam logic [3:0]  REG_TXST   = 4'h4;  // Last tx stats, low
  localparam logic [3:0]  REG_RXST   = 4'h8;  // Last rx stats
  localparam logic [3:0]  REG_TXHI   = 4'hC;  // Tx stats top bit
  localparam int          CTRL_VLAN  = 0;     // Tx VLAN handling on
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_DEC   = 2'h3;
endpackage
`default_nettype wire

// file: mfsr_sat_cnt.sv
/*
  Saturating up counter with synchronous clear; clear wins over count.
  Assumes a synchronised active-low reset and a single clock.
*/
`timescale 1ns/1ns
`default_nettype none
module mfsr_sat_cnt
#(
  parameter int          W   = 8,
  parameter logic [W-1:0] MAX = '1
)
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Control
  input  wire logic         clr,
  input  wire logic         inc,
  // Count
  output logic [W-1:0]      count
);
  logic [W-1:0] cnt_ff;      // Current count
  logic [W-1:0] nxt_cnt;     // Next count

  // Next count: hold at the ceiling rather than wrap
  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (clr)
      nxt_cnt = '0;
    else if (inc && cnt_ff != MAX)
      nxt_cnt = W'(cnt_ff + 1'b1);
  end

  // Register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end

  assign count = cnt_ff;
endmodule
`default_nettype wire

// file: mfsr_top.sv
/*
  Client-side reporting of a tri-speed Ethernet MAC: builds the per-frame
  transmit statistics word, forwards received bytes as a byte-wide
  stream with filter flags and receive statistics, and offers a small
  AXI4-Lite register window. Assumes the MAC engine drives the event
  inputs synchronously to mclk and the client never stalls the stream.
*/
`timescale 1ns/1ns
`default_nettype none
module mfsr_top
  import mfsr_pkg::*;
#(
  parameter bit          PFC_EN   = 1'b0,     // Priority flow built in
  parameter int          NFILT    = 4,        // Frame filters
  parameter logic [15:0] DEFER_MAX = 16'h0FA0 // Deferral limit, cycles
)
(
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  // Transmit engine events
  input  wire logic                   tx_attempt,    // Attempt starts
  input  wire logic                   tx_done,       // Frame finished
  input  wire logic                   tx_byte_act,   // DA..FCS on line
  input  wire logic [7:0]             tx_byte,       // Byte sent
  input  wire logic                   tx_collide,    // Collision pulse
  input  wire logic                   tx_late,       // Late collision
  input  wire logic                   tx_defer,      // Held off level
  input  wire logic                   tx_underrun,   // Underrun pulse
  input  wire logic                   tx_own_pause,  // Own pause frame
  input  wire logic                   tx_own_pfc,    // Own priority frame
  // Transmit statistics
  output logic [mfsr_pkg::TXS_W-1+PFC_EN:0] tx_stat,
  output logic                        tx_stat_valid,
  // Receive engine
  input  wire logic [7:0]             rx_in_data,
  input  wire logic                   rx_in_valid,
  input  wire logic                   rx_in_last,
  input  wire logic                   rx_in_err,
  input  wire logic [NFILT-1:0]       rx_in_filt,
  input  wire logic [27+PFC_EN:0]     rx_in_stats,
  input  wire logic                   rx_in_stats_valid,
  // Receive stream and statistics
  output logic [7:0]                  rx_tdata,
  output logic                        rx_tvalid,
  output logic                        rx_tlast,
  output logic                        rx_tuser,
  output logic [NFILT-1:0]            rx_filter,
  output logic [27+PFC_EN:0]          rx_stats,
  output logic                        rx_stats_valid,
  // AXI4-Lite slave
  input  wire logic [3:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [3:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready
);
  import mfsr_pkg::*;
  localparam int TW = TXS_W + 1;  // Internal word always has the top bit

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic [1:0] rst_sync_ff;  // Two-stage release
  logic       rst_n;        // Synchronised reset

  // Assert at once, release after two edges
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // ------------------------------------------------------------
  // Transmit counters
  // ------------------------------------------------------------
  logic [4:0]  att_cnt;   // Attempts this frame
  logic [4:0]  col_cnt;   // Colliding attempts
  logic [13:0] len_cnt;   // Bytes this attempt
  logic [15:0] def_cnt;   // Cycles held off

  // Length restarts with each attempt, saturates for jumbo frames
  mfsr_sat_cnt #(.W(14), .MAX(LEN_SAT)) u_len
  (
    .clk   (mclk),
    .rst_n (rst_n),
    .clr   (tx_attempt | tx_done),
    .inc   (tx_byte_act),
    .count (len_cnt)
  );
  // Attempts per frame, ceiling at sixteen
  mfsr_sat_cnt #(.W(5), .MAX(ATT_MAX)) u_att
  (
    .clk   (mclk),
    .rst_n (rst_n),
    .clr   (tx_done),
    .inc   (tx_attempt),
    .count (att_cnt)
  );
  // Attempts that met a collision
  mfsr_sat_cnt #(.W(5), .MAX(ATT_MAX)) u_col
  (
    .clk   (mclk),
    .rst_n (rst_n),
    .clr   (tx_done),
    .inc   (tx_collide),
    .count (col_cnt)
  );
  // Time spent deferring; stops at the limit
  mfsr_sat_cnt #(.W(16), .MAX(DEFER_MAX)) u_def
  (
    .clk   (mclk),
    .rst_n (rst_n),
    .clr   (tx_done),
    .inc   (tx_defer),
    .count (def_cnt)
  );

  // ------------------------------------------------------------
  // Transmit frame decode and flags
  // ------------------------------------------------------------
  logic [3:0] idx_ff, nxt_idx;          // Byte index in header
  logic       mcast_ff, nxt_mcast;      // DA group bit
  logic       bcast_ff, nxt_bcast;      // DA all ones so far
  logic       ctl_h_ff, nxt_ctl_h;      // Type high byte 88
  logic       tag_h_ff, nxt_tag_h;      // Type high byte 81
  logic       ctl_ff, nxt_ctl;          // Control frame
  logic       tag_ff, nxt_tag;          // Tagged frame
  logic       undr_ff, nxt_undr;        // Underrun seen
  logic       late_ff, nxt_late;        // Late collision seen
  logic       defd_ff, nxt_defd;        // Deferred at all
  logic       pause_ff, nxt_pause;      // Own pause frame
  logic       pfc_ff, nxt_pfc;          // Own priority frame
  logic       vlan_en_ff;               // Control register bit

  // Header decode restarts with each attempt; sticky flags live
  // until the frame is reported. An event in the reporting cycle
  // goes into that report, so the clear wins to spare the next one
  always_comb
  begin
    nxt_idx   = idx_ff;
    nxt_mcast = mcast_ff;
    nxt_bcast = bcast_ff;
    nxt_ctl_h = ctl_h_ff;
    nxt_tag_h = tag_h_ff;
    nxt_ctl   = ctl_ff;
    nxt_tag   = tag_ff;
    nxt_undr  = undr_ff;
    nxt_late  = late_ff;
    nxt_defd  = defd_ff;
    nxt_pause = pause_ff;
    nxt_pfc   = pfc_ff;
    if (tx_attempt)
      nxt_idx = IDX_DA0;
    else if (tx_byte_act)
    begin
      if (idx_ff == IDX_DA0)
      begin
        nxt_mcast = tx_byte[0];
        nxt_bcast = (tx_byte == BYTE_ALL1);
      end
      else if (idx_ff <= IDX_DA5)
        nxt_bcast = bcast_ff & (tx_byte == BYTE_ALL1);
      if (idx_ff == IDX_TYPE_H)
      begin
        nxt_ctl_h = (tx_byte == CTL_TYPE_H);
        nxt_tag_h = (tx_byte == TAG_TYPE_H);
      end
      if (idx_ff == IDX_TYPE_L)
      begin
        nxt_ctl = ctl_h_ff & (tx_byte == CTL_TYPE_L);
        nxt_tag = tag_h_ff & (tx_byte == TAG_TYPE_L);
      end
      if (idx_ff != IDX_END)
        nxt_idx = 4'(idx_ff + 1'b1);
    end
    if (tx_underrun)
      nxt_undr = 1'b1;
    if (tx_late)
      nxt_late = 1'b1;
    if (tx_defer)
      nxt_defd = 1'b1;
    if (tx_own_pause)
      nxt_pause = 1'b1;
    if (tx_own_pfc)
      nxt_pfc = 1'b1;
    if (tx_done)
    begin
      nxt_undr  = 1'b0;
      nxt_late  = 1'b0;
      nxt_defd  = 1'b0;
      nxt_pause = 1'b0;
      nxt_pfc   = 1'b0;
    end
  end

  // Register decode state
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idx_ff   <= 4'h0;
      mcast_ff <= 1'b0;
      bcast_ff <= 1'b0;
      ctl_h_ff <= 1'b0;
      tag_h_ff <= 1'b0;
      ctl_ff   <= 1'b0;
      tag_ff   <= 1'b0;
      undr_ff  <= 1'b0;
      late_ff  <= 1'b0;
      defd_ff  <= 1'b0;
      pause_ff <= 1'b0;
      pfc_ff   <= 1'b0;
    end
    else
    begin
      idx_ff   <= nxt_idx;
      mcast_ff <= nxt_mcast;
      bcast_ff <= nxt_bcast;
      ctl_h_ff <= nxt_ctl_h;
      tag_h_ff <= nxt_tag_h;
      ctl_ff   <= nxt_ctl;
      tag_ff   <= nxt_tag;
      undr_ff  <= nxt_undr;
      late_ff  <= nxt_late;
      defd_ff  <= nxt_defd;
      pause_ff <= nxt_pause;
      pfc_ff   <= nxt_pfc;
    end
  end

  // ------------------------------------------------------------
  // Transmit statistics word
  // ------------------------------------------------------------
  logic [TW-1:0] txw_ff, nxt_txw;   // Latched word, bit 30 unused
  logic          txv_ff;            // Valid strobe
  logic          byte_ff;           // Live byte-in-flight copy
  logic          priority_flow_sent_flag;
  logic          deferral_limit_hit;
  logic          tagged_frame_flag;
  logic          clean_send_flag;
  logic          xcol;
  logic          undr_now, late_now;

  // Events arriving with the done pulse still count for this frame
  assign undr_now = undr_ff | tx_underrun;
  assign late_now = late_ff | tx_late;
  assign xcol     = (col_cnt == ATT_MAX) && (att_cnt == ATT_MAX);
  assign priority_flow_sent_flag = PFC_EN & (pfc_ff | tx_own_pfc);
  assign deferral_limit_hit = (def_cnt == DEFER_MAX);
  assign tagged_frame_flag  = tag_ff & vlan_en_ff;
  // Any error of any kind withholds success
  assign clean_send_flag = ~(undr_now | late_now | xcol |
                             deferral_limit_hit);

  // Build the word when the frame finishes; hold it otherwise
  always_comb
  begin
    nxt_txw = txw_ff;
    if (tx_done)
    begin
      nxt_txw = '0;
      nxt_txw[TXS_PFC]   = priority_flow_sent_flag;
      nxt_txw[TXS_PAUSE] = pause_ff | tx_own_pause;
      nxt_txw[TXS_ATT_HI:TXS_ATT_LO] = 4'(att_cnt - 1'b1);
      nxt_txw[TXS_XCOL]  = xcol;
      nxt_txw[TXS_LATE]  = late_now;
      nxt_txw[TXS_XDEF]  = deferral_limit_hit;
      nxt_txw[TXS_DEF]   = defd_ff | tx_defer;
      nxt_txw[TXS_VLAN]  = tagged_frame_flag;
      nxt_txw[TXS_LEN_HI:TXS_LEN_LO] = len_cnt;
      nxt_txw[TXS_CTRL]  = ctl_ff;
      nxt_txw[TXS_UNDR]  = undr_now;
      nxt_txw[TXS_MCAST] = mcast_ff;
      nxt_txw[TXS_BCAST] = bcast_ff;
      nxt_txw[TXS_CLEAN] = clean_send_flag;
    end
  end

  // Register word, strobe and live byte flag
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txw_ff  <= '0;
      txv_ff  <= 1'b0;
      byte_ff <= 1'b0;
    end
    else
    begin
      txw_ff  <= nxt_txw;
      txv_ff  <= tx_done;
      byte_ff <= tx_byte_act;
    end
  end

  // Bit 30 follows the line every cycle; it lags the data by one
  // cycle so it must not qualify PHY data
  always_comb
  begin
    tx_stat = txw_ff[TXS_W-1+PFC_EN:0];
    tx_stat[TXS_BYTE] = byte_ff;
  end
  assign tx_stat_valid = txv_ff;

  // ------------------------------------------------------------
  // Receive stream and statistics
  // ------------------------------------------------------------
  // One register stage, no backpressure: the client must take each
  // beat
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_tdata       <= 8'h00;
      rx_tvalid      <= 1'b0;
      rx_tlast       <= 1'b0;
      rx_tuser       <= 1'b0;
      rx_filter      <= '0;
      rx_stats       <= '0;
      rx_stats_valid <= 1'b0;
    end
    else
    begin
      rx_tdata  <= rx_in_data;
      rx_tvalid <= rx_in_valid;
      rx_tlast  <= rx_in_valid & rx_in_last;
      rx_tuser  <= rx_in_valid & rx_in_last & rx_in_err;
      rx_filter <= rx_in_filt;
      if (rx_in_stats_valid)
        rx_stats <= rx_in_stats;
      rx_stats_valid <= rx_in_stats_valid;
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------
  logic        aw_ff, nxt_aw;     // Address held
  logic        w_ff, nxt_w;       // Data held
  logic [3:0]  wa_ff, nxt_wa;     // Write address
  logic [31:0] wd_ff, nxt_wd;     // Write data
  logic        ws_ff, nxt_ws;     // Low byte lane enabled
  logic        bv_ff, nxt_bv;     // Write answer pending
  logic [1:0]  br_ff, nxt_br;     // Write answer code
  logic        nxt_vlan;
  logic        rv_ff, nxt_rv;     // Read answer pending
  logic [31:0] rd_ff, nxt_rd;     // Read data
  logic [1:0]  rr_ff, nxt_rr;     // Read answer code

  assign s_axi_awready = ~aw_ff & ~bv_ff;
  assign s_axi_wready  = ~w_ff & ~bv_ff;
  assign s_axi_arready = ~rv_ff;

  // Address and data are taken in any order; the write lands once
  // both are held, and only then is the answer raised
  always_comb
  begin
    nxt_aw   = aw_ff | (s_axi_awvalid & s_axi_awready);
    nxt_w    = w_ff | (s_axi_wvalid & s_axi_wready);
    nxt_wa   = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : wa_ff;
    nxt_wd   = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wd_ff;
    nxt_ws   = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb[0] : ws_ff;
    nxt_bv   = bv_ff & ~s_axi_bready;
    nxt_br   = br_ff;
    nxt_vlan = vlan_en_ff;
    if (aw_ff && w_ff)
    begin
      nxt_aw = 1'b0;
      nxt_w  = 1'b0;
      nxt_bv = 1'b1;
      nxt_br = RESP_OKAY;
      unique case (wa_ff)
        REG_CTRL: if (ws_ff) nxt_vlan = wd_ff[CTRL_VLAN];
        REG_TXST, REG_RXST, REG_TXHI: nxt_br = RESP_OKAY;
        default: nxt_br = RESP_DEC;  // Unmapped word
      endcase
    end
    // Read: one answer at a time, data from flops
    nxt_rv = rv_ff & ~s_axi_rready;
    nxt_rd = rd_ff;
    nxt_rr = rr_ff;
    if (s_axi_arvalid && s_axi_arready)
    begin
      nxt_rv = 1'b1;
      nxt_rd = 32'h0000_0000;
      nxt_rr = RESP_OKAY;
      unique case (s_axi_araddr)
        REG_CTRL: nxt_rd[CTRL_VLAN] = vlan_en_ff;
        REG_TXST: nxt_rd = tx_stat[TXS_W-1:0];
        REG_RXST: nxt_rd[27+PFC_EN:0] = rx_stats;
        REG_TXHI: nxt_rd[0] = txw_ff[TXS_PFC];
        default: nxt_rr = RESP_DEC;
      endcase
    end
  end

  // Register bus state
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      wa_ff <= 4'h0;
      wd_ff <= 32'h0000_0000;
      ws_ff <= 1'b0;
      bv_ff <= 1'b0;
      br_ff <= 2'h0;
      vlan_en_ff <= 1'b0;
      rv_ff <= 1'b0;
      rd_ff <= 32'h0000_0000;
      rr_ff <= 2'h0;
    end
    else
    begin
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      wa_ff <= nxt_wa;
      wd_ff <= nxt_wd;
      ws_ff <= nxt_ws;
      bv_ff <= nxt_bv;
      br_ff <= nxt_br;
      vlan_en_ff <= nxt_vlan;
      rv_ff <= nxt_rv;
      rd_ff <= nxt_rd;
      rr_ff <= nxt_rr;
    end
  end
  assign s_axi_bvalid = bv_ff;
  assign s_axi_bresp  = br_ff;
  assign s_axi_rvalid = rv_ff;
  assign s_axi_rdata  = rd_ff;
  assign s_axi_rresp  = rr_ff;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_tx_strobe: assert property (tx_done |=> tx_stat_valid ##1 (!tx_stat_valid || $past(tx_done))) else $error("tx strobe not one cycle after done");
  a_rsv_zero: assert property (!tx_stat[TXS_RSV_HI] && !tx_stat[TXS_RSV_LO]) else $error("reserved tx bits set");
  a_byte_live: assert property (tx_stat[TXS_BYTE] == $past(tx_byte_act)) else $error("byte flag not live");
  a_len_cap: assert property (tx_stat[TXS_LEN_HI:TXS_LEN_LO] <= LEN_SAT) else $error("length over ceiling");
  a_clean_ok: assert property (tx_stat_valid && tx_stat[TXS_CLEAN] |-> !tx_stat[TXS_UNDR] && !tx_stat[TXS_LATE] && !tx_stat[TXS_XCOL]) else $error("success with error");
  a_under_rep: assert property (tx_done && (undr_ff || tx_underrun) |=> tx_stat[TXS_UNDR] && !tx_stat[TXS_CLEAN]) else $error("underrun lost");
  a_rx_beat: assert property (rx_in_valid |=> rx_tvalid && rx_tdata == $past(rx_in_data)) else $error("rx beat not forwarded");
  a_rx_user: assert property (rx_tuser |-> rx_tvalid && rx_tlast) else $error("tuser off last beat");
  a_rx_filt: assert property (rx_in_valid |=> rx_filter == $past(rx_in_filt)) else $error("filter flags lost");
  a_rx_stats: assert property (rx_in_stats_valid |=> rx_stats_valid && rx_stats == $past(rx_in_stats)) else $error("rx stats not latched");
endmodule
`default_nettype wire

// file: mfsr_client.sv
/* Client model: takes every stream beat, counts frames and bad ones.
   Assumes the active-high receive stream on mclk. */
`timescale 1ns/1ns
`default_nettype none
module mfsr_client
(
  // Stream in
  input  wire logic mclk,
  input  wire logic tv,
  input  wire logic tl,
  input  wire logic tu,
  // Counts
  output var int    frames,
  output var int    bad
);
  // No ready exists, so each beat is taken as offered
  always @(posedge mclk)
  begin
    frames <= frames + 32'(tv & tl);
    bad <= bad + 32'(tv & tl & tu);
  end
endmodule
`default_nettype wire

// file: tb_mac_frame_stats_rx_stream_if.sv
/* Bench for mfsr_top: tx frames, rx stream and register window.
   Assumes mfsr_pkg and mfsr_client compiled first. */
`timescale 1ns/1ns
`default_nettype none
module tb_mac_frame_stats_rx_stream_if;
  import mfsr_pkg::*;
  logic mclk, nrst, tx_attempt, tx_done, tx_byte_act, tx_collide, tx_late;
  logic tx_defer, tx_underrun, tx_own_pause, tx_own_pfc, tx_stat_valid;
  logic rx_in_valid, rx_in_last, rx_in_err, rx_in_stats_valid, rx_tvalid;
  logic rx_tlast, rx_tuser, rx_stats_valid, s_axi_awvalid, s_axi_awready;
  logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, vl, mon, er;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, rx_in_filt, rx_filter;
  logic [7:0] tx_byte, rx_in_data, rx_tdata;
  logic [27:0] rx_in_stats, rx_stats, es;
  logic [31:0] tx_stat, s_axi_wdata, s_axi_rdata, seed, rd, e, p;
  int err_total, total_checks, frames, bad, nb, n;
  wire [16:0] o = {rx_filter & {4{rx_tvalid}}, rx_tvalid, rx_tdata, rx_tlast,
                   rx_tuser, rx_stats_valid, tx_stat_valid};
  // Deferral limit cut to 16 cycles to keep runs short
  mfsr_top #(.DEFER_MAX(16'h0010)) u_dut (.mclk, .nrst, .tx_attempt,
    .tx_done, .tx_byte_act, .tx_byte, .tx_collide, .tx_late, .tx_defer,
    .tx_underrun, .tx_own_pause, .tx_own_pfc, .tx_stat, .tx_stat_valid,
    .rx_in_data, .rx_in_valid, .rx_in_last, .rx_in_err, .rx_in_filt,
    .rx_in_stats, .rx_in_stats_valid, .rx_tdata, .rx_tvalid, .rx_tlast,
    .rx_tuser, .rx_filter, .rx_stats, .rx_stats_valid, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  mfsr_client u_cli (.mclk(mclk), .tv(rx_tvalid), .tl(rx_tlast),
    .tu(rx_tuser), .frames(frames), .bad(bad));
  initial forever #50 mclk = ~mclk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string s, logic [31:0] x, y);
    total_checks++;
    if (x !== y)
    begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", s, x, y);
    end
  endtask
  // One bus cycle from a rising edge; each channel dropped once taken
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
    @(posedge mclk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    do
    begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready));
    {s_axi_bready, s_axi_rready} <= 2'h0;
    {rd, rsp} = w ? {32'h0, s_axi_bresp} : {s_axi_rdata, s_axi_rresp};
  endtask
  // Frame with att attempts (all colliding if more than one)
  task automatic txc(int att, len, dfr, logic [7:0] da, th, tl, logic u, ps);
    e = {ps, 2'h0, 4'(att - 1), 1'b0, att == 16, u, dfr + 1 >= 16, dfr > 0,
         vl && th == 8'h81 && tl == 8'h00,
         len > 16368 ? 14'h3FF0 : 14'(len), th == 8'h88 && tl == 8'h08,
         u, da[0], &da, !u && att < 16 && dfr + 1 < 16};
    tx_defer <= dfr > 0;
    repeat (dfr + 1) @(posedge mclk);
    tx_defer <= 1'b0;
    repeat (att)
    begin
      tx_attempt <= 1'b1;
      for (int b = 0; b <= len; b++)
      begin
        @(posedge mclk);
        {tx_attempt, tx_byte_act, tx_underrun, tx_collide, tx_late} <=
          {1'b0, b < len, u && b == 20, att > 1 && b == len, u && b == len};
        tx_byte <= b < 6 ? da : b == 12 ? th : b == 13 ? tl : 8'(rnd());
      end
      @(posedge mclk);
      {tx_collide, tx_late} <= 2'h0;
    end
    {tx_done, tx_own_pause, tx_own_pfc} <= {1'b1, ps, ps};
    @(posedge mclk);
    {tx_done, tx_own_pause, tx_own_pfc} <= 3'h0;
    @(negedge mclk);
    chk("tx_stat", e, tx_stat);
  endtask
  // Expected stream is the input one cycle late
  always @(posedge mclk)
  begin
    p <= 32'({rx_in_filt & {4{rx_in_valid}}, rx_in_valid, rx_in_data,
      rx_in_valid & rx_in_last, rx_in_valid & rx_in_last & rx_in_err,
      rx_in_stats_valid, tx_done});
    if (rx_in_stats_valid) es <= rx_in_stats;
  end
  always @(negedge mclk)
  if (mon)
  begin
    chk("stream", p, 32'(o));
    chk("rx_stats", 32'(es), 32'(rx_stats));
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #6000000;
    err_total++;
    print_verdict();
  end
  initial
  begin
    {mclk, nrst, tx_attempt, tx_done, tx_byte_act, tx_byte, tx_collide, tx_late,
     tx_defer, tx_underrun, tx_own_pause, tx_own_pfc, rx_in_data, rx_in_valid,
     rx_in_last, rx_in_err, rx_in_filt, rx_in_stats, rx_in_stats_valid, vl, mon,
     es, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready,
     s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_wstrb, seed} = {4'hF, 32'h00000013};
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    mon <= 1'b1;
    txc(1, 64, 0, 8'hFF, 8'h88, 8'h08, 1'b0, 1'b1);
    bus(1'b1, REG_TXST, 32'hFFFFFFFF);
    bus(1'b0, REG_TXST, 32'h0);
    chk("reg_tx", e, rd);
    bus(1'b0, REG_TXHI, 32'h0);
    chk("reg_txhi", 32'h0, rd);
    txc(3, 60, 3, 8'h01, 8'h81, 8'h00, 1'b1, 1'b0);
    bus(1'b1, REG_CTRL, 32'h1);
    vl = 1'b1;
    txc(16, 30, 40, 8'h02, 8'h81, 8'h00, 1'b0, 1'b0);
    repeat (3) txc(int'(rnd() % 3) + 1, int'(rnd() % 90) + 21, 0, 8'(rnd()),
      8'(rnd()), 8'(rnd()), rnd() % 2 != 0, 1'b0);
    txc(1, 16370, 0, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
    $display("tx tests done");
    for (int f = 0; f < 6; f++)
    begin
      {er, n} = {rnd() % 2 != 0, int'(rnd() % 40) + 1};
      nb += er;
      for (int i = 0; i <= n; i++)
      begin
        {rx_in_valid, rx_in_last, rx_in_stats_valid, rx_in_err} <=
          {i < n, i == n - 1, i == n - 1, er};
        {rx_in_data, rx_in_filt, rx_in_stats} <= 40'({rnd(), rnd()});
        @(posedge mclk);
      end
    end
    repeat (2) @(posedge mclk);
    chk("frames", 6, frames);
    chk("bad", nb, bad);
    bus(1'b0, REG_RXST, 32'h0);
    chk("reg_rx", 32'(es), rd);
    bus(1'b0, 4'h2, 32'h0);
    chk("decerr", 32'(RESP_DEC), 32'(rsp));
    $display("rx and register tests done");
    print_verdict();
  end
endmodule
`default_nettype wire
